// file: pkg/ipt_pkg.sv
package ipt_pkg;
    // Configuration byte offsets
    localparam logic [7:0] BM_BASE_OFS = 8'h20;
    localparam logic [7:0] PRI_TIM_OFS = 8'h40;
    localparam logic [7:0] SEC_TIM_OFS = 8'h42;
    localparam logic [7:0] D1_TIM_OFS = 8'h44;

    // Reset values
    localparam logic [31:0] BM_BASE_RESET = 32'h0000_0001;
    localparam logic [15:0] CHAN_TIM_RESET = 16'h0000;
    localparam logic [7:0] D1_TIM_RESET = 8'h00;

    // Bus-master base register layout
    localparam int BM_BASE_LSB = 4;
    localparam int BM_BASE_MSB = 15;
    localparam logic BM_IO_FLAG = 1'b1;

    // Channel timing register layout
    localparam int DECODE_EN_BIT = 15;
    localparam int PER_DRIVE_BIT = 14;
    localparam int SAMPLE_LSB = 12;
    localparam int RECOV_LSB = 8;
    localparam int DMA_ONLY_D1_BIT = 7;
    localparam int PREFETCH_D1_BIT = 6;
    localparam int READY_D1_BIT = 5;
    localparam int FAST_D1_BIT = 4;
    localparam int DMA_ONLY_D0_BIT = 3;
    localparam int PREFETCH_D0_BIT = 2;
    localparam int READY_D0_BIT = 1;
    localparam int FAST_D0_BIT = 0;

    // Second drive timing layout, primary at 3:0, secondary at 7:4
    localparam int D1_SAMPLE_LSB = 2;
    localparam int D1_RECOV_LSB = 0;
    localparam int D1_CHAN_STRIDE = 4;

    // Legacy cable port addresses
    localparam logic [15:0] PRI_CMD_BASE = 16'h01f0;
    localparam logic [15:0] SEC_CMD_BASE = 16'h0170;
    localparam logic [15:0] PRI_CTL_ADDR = 16'h03f6;
    localparam logic [15:0] SEC_CTL_ADDR = 16'h0376;
    localparam logic [2:0] DATA_PORT_OFS = 3'h0;
    localparam logic [2:0] DRIVE_SEL_OFS = 3'h6;
    localparam int DRIVE_SEL_BIT = 4;

    // Compatible timing codes, slowest setting
    localparam logic [1:0] COMPAT16_SAMPLE_CODE = 2'h0;
    localparam logic [1:0] COMPAT16_RECOV_CODE = 2'h0;
    localparam logic [1:0] COMPAT8_SAMPLE_CODE = 2'h0;
    localparam logic [1:0] COMPAT8_RECOV_CODE = 2'h0;

    // Code 00 gives the largest count, each step one clock less
    localparam logic [2:0] SAMPLE_MAX_CLKS = 3'h5;
    localparam logic [2:0] RECOV_MAX_CLKS = 3'h4;

    typedef logic [2:0] ipt_cnt_t;

    function automatic ipt_cnt_t ipt_sample_clks(input logic [1:0] code);
        return SAMPLE_MAX_CLKS - {1'b0, code};
    endfunction

    function automatic ipt_cnt_t ipt_recov_clks(input logic [1:0] code);
        return RECOV_MAX_CLKS - {1'b0, code};
    endfunction
endpackage

// file: pkg/ipt_timing_if.sv
interface ipt_timing_if;
    logic start;
    ipt_pkg::ipt_cnt_t sample_clks;
    ipt_pkg::ipt_cnt_t recov_clks;
    logic ready_en;
    logic fast;
    logic prefetch;
    logic wr;
    logic busy;
    logic done;

    modport ctrl (
        output start,
        output sample_clks,
        output recov_clks,
        output ready_en,
        output fast,
        output prefetch,
        output wr,
        input busy,
        input done
    );

    modport timer (
        input start,
        input sample_clks,
        input recov_clks,
        input ready_en,
        input fast,
        input prefetch,
        input wr,
        output busy,
        output done
    );
endinterface

// file: verif/ipt_drive_model.sv
module ipt_drive_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Cable side
    input wire logic [1:0] strobe_i,
    input wire logic [3:0] wait_i,
    output logic [1:0] iordy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_r [2];
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        always_ff @(posedge mclk_i)
        begin
            if (!rst_n_i || !strobe_i[c])
                cnt_r[c] <= 4'h0;
            else if (cnt_r[c] != 4'hf)
                cnt_r[c] <= cnt_r[c] + 4'h1;
        end
        // Pulled up when no cycle runs
        assign iordy_o[c] = !strobe_i[c] || (cnt_r[c] >= wait_i);
    end
endmodule // ipt_drive_model

// file: verif/ipt_ide_timing_assertions.sv
module ipt_ide_timing_checker (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Configuration and I/O requests
    input wire logic cfg_req_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic io_req_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_claim_o,
    input wire logic io_ack_o,
    input wire logic bm_hit_o,
    // Cable side
    input wire logic [1:0] strobe_o,
    input wire logic [1:0] busy_o,
    input wire logic [1:0] done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_strobe_two;
        strobe_o[0] [*2];
    endsequence
    sequence s_recover;
        strobe_o[0] ##1 (!strobe_o[0] && busy_o[0]);
    endsequence

    property p_rd_answer;
        cfg_req_i && !cfg_wr_i |=> cfg_rvalid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("config read got no answer");
    property p_base_fixed;
        cfg_rvalid_o && $past(cfg_addr_i[7:2]) == 6'h08 |->
            cfg_rdata_o[0] && cfg_rdata_o[31:16] == 16'h0 &&
            cfg_rdata_o[3:2] == 2'h0;
    endproperty
    a_base_fixed: assert property (p_base_fixed)
        else $error("base register fixed bits wrong");
    property p_bm_hit;
        bm_hit_o |-> io_req_i && !io_claim_o;
    endproperty
    a_bm_hit: assert property (p_bm_hit)
        else $error("window hit without request");
    property p_ack_claim;
        io_ack_o |-> io_claim_o && io_req_i;
    endproperty
    a_ack_claim: assert property (p_ack_claim)
        else $error("accept without claim");
    property p_strobe_start;
        $rose(strobe_o[0]) |-> $past(io_ack_o) and s_strobe_two;
    endproperty
    a_strobe_start: assert property (p_strobe_start)
        else $error("strobe start or length wrong");
    property p_done_end;
        done_o[0] |-> s_recover;
    endproperty
    a_done_end: assert property (p_done_end)
        else $error("no recovery after sample");
    property p_busy_hold;
        busy_o[0] && !strobe_o[0] |=> !strobe_o[0];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("strobe straight after recovery");
    property p_busy_refuse;
        busy_o[0] && io_addr_i[7] |-> !io_ack_o;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("accepted while channel busy");
endmodule // ipt_ide_timing_checker

bind ipt_ide_timing ipt_ide_timing_checker u_chk (.mclk_i, .rst_n_i,
    .cfg_req_i, .cfg_wr_i, .cfg_addr_i, .cfg_rdata_o, .cfg_rvalid_o,
    .io_req_i, .io_addr_i, .io_claim_o, .io_ack_o, .bm_hit_o,
    .strobe_o, .busy_o, .done_o);

// file: verif/ipt_ide_timing_tb.sv
module ipt_ide_timing_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i, rst_n_i, cfg_req_i, cfg_wr_i, cfg_rvalid_o;
    logic [7:0] cfg_addr_i;
    logic [3:0] cfg_be_i, wt;
    logic [31:0] cfg_wdata_i, cfg_rdata_o;
    logic io_req_i, io_wr_i, io_dma_i, io_claim_o, io_ack_o, bm_hit_o;
    logic [15:0] io_addr_i;
    logic [7:0] io_wdata_i;
    logic [1:0] iordy_i, strobe_o, wr_o, fast_o, prefetch_o;
    logic [1:0] busy_o, done_o, drive_sel_o;
    logic fst, pf, wv;
    int s, r, fails, samples_checked;

    ipt_ide_timing uut (.mclk_i, .rst_n_i, .cfg_req_i, .cfg_wr_i,
        .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o,
        .io_req_i, .io_addr_i, .io_wr_i, .io_dma_i, .io_wdata_i, .io_claim_o,
        .io_ack_o, .bm_hit_o, .iordy_i, .strobe_o, .wr_o, .fast_o,
        .prefetch_o, .busy_o, .done_o, .drive_sel_o);
    ipt_drive_model u_drv (.mclk_i, .rst_n_i, .strobe_i(strobe_o),
        .wait_i(wt), .iordy_o(iordy_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic end_of_test();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cw(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        cfg_req_i = 1'b1;
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_be_i = be;
        @(posedge mclk_i);
        #1 cfg_req_i = 1'b0;
        // Idle cycle so the next call never retoggles in one step
        @(posedge mclk_i);
        #1;
    endtask

    task automatic cr(input logic [7:0] a, input logic [31:0] e);
        cfg_req_i = 1'b1;
        cfg_wr_i = 1'b0;
        cfg_addr_i = a;
        @(posedge mclk_i);
        #1 cfg_req_i = 1'b0;
        chk({31'h0, cfg_rvalid_o}, 32'h1);
        chk(cfg_rdata_o, e);
        @(posedge mclk_i);
        #1;
    endtask

    // Decode flags read mid-cycle; only unclaimed addresses probed
    task automatic probe(input logic [15:0] a, input logic cl, bm);
        io_req_i = 1'b1;
        io_addr_i = a;
        @(negedge mclk_i);
        chk({io_claim_o, bm_hit_o}, {cl, bm});
        @(posedge mclk_i);
        #1 io_req_i = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic io(input logic [15:0] a, input logic w, d,
        input logic [7:0] wd);
        int c;
        int n;
        logic got;
        c = a[7] ? 0 : 1;
        io_req_i = 1'b1;
        io_addr_i = a;
        io_wr_i = w;
        io_dma_i = d;
        io_wdata_i = wd;
        n = 0;
        // Ack read mid-cycle, away from the edge that acts on it
        do
        begin
            @(negedge mclk_i);
            got = io_ack_o;
            @(posedge mclk_i);
            n++;
        end
        while (got !== 1'b1 && n < 40);
        #1 io_req_i = 1'b0;
        s = 0;
        r = 0;
        while (strobe_o[c] === 1'b1 && s < 40)
        begin
            fst = fast_o[c];
            pf = prefetch_o[c];
            wv = wr_o[c];
            s++;
            @(posedge mclk_i);
            #1;
        end
        while (busy_o[c] === 1'b1 && r < 40)
        begin
            r++;
            @(posedge mclk_i);
            #1;
        end
    endtask

    // Channel word: decode on, same code for sample and recovery
    function automatic logic [15:0] tw(input logic [1:0] sc,
        input logic per, input logic [7:0] low);
        return {1'b1, per, sc, 2'h0, sc, low};
    endfunction

    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        end_of_test();
    end

    initial
    begin
        {rst_n_i, cfg_req_i, cfg_wr_i, io_req_i, io_wr_i, io_dma_i} = 6'h0;
        {cfg_addr_i, cfg_be_i, cfg_wdata_i, io_addr_i, io_wdata_i} = '0;
        wt = 4'h0;
        fails = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        cr(8'h20, 32'h1);
        cr(8'h40, 32'h0);
        cr(8'h44, 32'h0);
        cw(8'h20, 32'hffff_ffff, 4'hf);
        cr(8'h20, 32'h0000_fff1);
        cr(8'h60, 32'h0);
        probe(16'hfff3, 1'b0, 1'b1);
        probe(16'h01f0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            cw(8'h40, {16'h0, tw(i[1:0], 1'b0, 8'h01)}, 4'h3);
            io(16'h01f0, 1'b0, 1'b0, 8'h00);
            chk(s, 5 - i);
            chk(r, 4 - i);
            chk(fst, 1'b1);
        end
        // Rewrite timing mid-access, then retry while busy
        cw(8'h40, {16'h0, tw(2'h0, 1'b0, 8'h01)}, 4'h3);
        fork
            io(16'h01f0, 1'b0, 1'b0, 8'h00);
            begin
                repeat (2) @(posedge mclk_i);
                #1;
                cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h01)}, 4'h3);
                io_req_i = 1'b1;
                io_addr_i = 16'h01f7;
                @(negedge mclk_i);
                chk({io_claim_o, io_ack_o}, 2'h2);
                @(posedge mclk_i);
                #1 io_req_i = 1'b0;
            end
        join
        chk({s[3:0], r[3:0]}, 8'h54);
        probe(16'h0170, 1'b0, 1'b0);
        io(16'h01f7, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], r[3:0], 7'h0, fst}, 16'h5400);
        cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h00)}, 4'h3);
        io(16'h01f0, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], 2'h0, wv, fst}, 8'h50);
        cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h09)}, 4'h3);
        io(16'h01f0, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], 3'h0, fst}, 8'h50);
        io(16'h01f0, 1'b0, 1'b1, 8'h00);
        chk({s[3:0], 3'h0, fst}, 8'h21);
        cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h05)}, 4'h3);
        io(16'h01f0, 1'b1, 1'b0, 8'h00);
        chk({pf, wv}, 2'h3);
        cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h01)}, 4'h3);
        wt = 4'h6;
        io(16'h01f0, 1'b1, 1'b0, 8'h00);
        chk({pf, s[3:0]}, 5'h02);
        cw(8'h40, {16'h0, tw(2'h3, 1'b0, 8'h03)}, 4'h3);
        io(16'h01f0, 1'b0, 1'b0, 8'h00);
        chk(s > 2, 1'b1);
        wt = 4'h0;
        cw(8'h44, 32'h69, 4'h1);
        cw(8'h40, {tw(2'h3, 1'b1, 8'h10), tw(2'h3, 1'b0, 8'h10)}, 4'hf);
        io(16'h01f6, 1'b1, 1'b0, 8'h10);
        chk(drive_sel_o, 2'h1);
        io(16'h01f0, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], r[3:0]}, 8'h21);
        cw(8'h40, {tw(2'h3, 1'b1, 8'h10), tw(2'h3, 1'b1, 8'h10)}, 4'hf);
        cr(8'h40, {tw(2'h3, 1'b1, 8'h10), tw(2'h3, 1'b1, 8'h10)});
        io(16'h01f0, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], r[3:0]}, 8'h33);
        io(16'h0176, 1'b1, 1'b0, 8'h10);
        io(16'h0170, 1'b0, 1'b0, 8'h00);
        chk({s[3:0], r[3:0]}, 8'h42);
        end_of_test();
    end
endmodule // ipt_ide_timing_tb

// file: verilog/ipt_cycle_timer.sv
module ipt_cycle_timer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Timing selection from the controller
    ipt_timing_if.timer tif,
    // Cable side
    input wire logic iordy_i,
    output logic strobe_o,
    output logic fast_o,
    output logic prefetch_o,
    output logic wr_o
);
    typedef enum {ST_IDLE, ST_STROBE, ST_RECOV} ipt_state_e;

    ipt_state_e state_r;
    ipt_state_e state_nxt;
    ipt_pkg::ipt_cnt_t cnt_r;
    ipt_pkg::ipt_cnt_t cnt_nxt;
    ipt_pkg::ipt_cnt_t sample_r;
    ipt_pkg::ipt_cnt_t recov_r;
    logic ready_en_r;
    logic fast_r;
    logic prefetch_r;
    logic wr_r;
    logic ready_seen;
    logic sample_hit;
    logic latch;

    // RULE10: forced ready when off
    assign ready_seen = !ready_en_r || iordy_i;
    // RULE11: sample at set point
    assign sample_hit = (state_r == ST_STROBE) && (cnt_r >= sample_r)
                        && ready_seen;
    assign latch = (state_r == ST_IDLE) && tif.start;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE:
            begin
                if (tif.start)
                begin
                    state_nxt = ST_STROBE;
                    cnt_nxt = 3'h1;
                end
            end
            // RULE6: strobe to first sample
            ST_STROBE:
            begin
                if (sample_hit)
                begin
                    state_nxt = ST_RECOV;
                    cnt_nxt = 3'h1;
                end
                else if (cnt_r < sample_r)
                begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            // RULE7: recovery before next strobe
            ST_RECOV:
            begin
                if (cnt_r >= recov_r)
                begin
                    state_nxt = ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                cnt_nxt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // RULE22: timing frozen per access
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            sample_r <= ipt_pkg::SAMPLE_MAX_CLKS;
            recov_r <= ipt_pkg::RECOV_MAX_CLKS;
            ready_en_r <= 1'b0;
            fast_r <= 1'b0;
            prefetch_r <= 1'b0;
            wr_r <= 1'b0;
        end
        else if (latch)
        begin
            sample_r <= tif.sample_clks;
            recov_r <= tif.recov_clks;
            ready_en_r <= tif.ready_en;
            fast_r <= tif.fast;
            prefetch_r <= tif.prefetch;
            wr_r <= tif.wr;
        end
    end

    assign tif.busy = (state_r != ST_IDLE);
    assign tif.done = sample_hit;
    assign strobe_o = (state_r == ST_STROBE);
    assign fast_o = fast_r;
    assign prefetch_o = prefetch_r;
    assign wr_o = wr_r;
endmodule // ipt_cycle_timer

// file: verilog/ipt_ide_timing.sv
// Behaviour
// RULE1: Base field bits 15:4 select I/O window
// RULE2: Base bit 0 reads one, I/O
// RULE3: Base bits 31:16, 3:2 read zero
// RULE4: Decode enable claims channel ports
// RULE5: Per-drive enable picks drive-1 register
// RULE6: Sample code gives 5,4,3,2 clocks
// RULE7: Recovery code gives 4,3,2,1 clocks
// RULE8: DMA-only bit limits fast to DMA
// RULE9: Prefetch/post only when bit set
// RULE10: Ready sampling off forces ready
// RULE11: Ready sampled for selected drive
// RULE12: Fast bank off uses 16-bit compatible
// RULE13: Fast bank on, selected, uses fast
// RULE14: Non-data ports use 8-bit compatible
// RULE15: Separate channel registers at 40h, 42h
// RULE16: Drive-1 register idle unless enabled
// RULE17: Secondary drive-1 sample in 7:6
// RULE18: Secondary drive-1 recovery in 5:4
// RULE19: Primary drive-1 sample in 3:2
// RULE20: Primary drive-1 recovery in 1:0
// RULE21: Timing registers reset to zero
// RULE22: Timing held stable during access
module ipt_ide_timing (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Configuration space access
    input wire logic cfg_req_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // PCI I/O cycle requests
    input wire logic io_req_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_dma_i,
    input wire logic [7:0] io_wdata_i,
    output logic io_claim_o,
    output logic io_ack_o,
    output logic bm_hit_o,
    // Cable side, index 0 primary, 1 secondary
    input wire logic [1:0] iordy_i,
    output logic [1:0] strobe_o,
    output logic [1:0] wr_o,
    output logic [1:0] fast_o,
    output logic [1:0] prefetch_o,
    output logic [1:0] busy_o,
    output logic [1:0] done_o,
    output logic [1:0] drive_sel_o
);
    logic [ipt_pkg::BM_BASE_MSB:ipt_pkg::BM_BASE_LSB] bm_base_r;
    logic [1:0][15:0] chan_tim_r;
    logic [7:0] d1_tim_r;
    logic [1:0] drive_sel_r;
    logic [31:0] cfg_rdata_r;
    logic cfg_rvalid_r;
    logic [1:0] hit;
    logic [1:0] acc;
    logic [1:0] sel_wr;

    // Configuration decode
    wire cfg_wr = cfg_req_i && cfg_wr_i;
    wire cfg_rd = cfg_req_i && !cfg_wr_i;
    wire sel_bm = (cfg_addr_i[7:2] == ipt_pkg::BM_BASE_OFS[7:2]);
    wire sel_tim = (cfg_addr_i[7:2] == ipt_pkg::PRI_TIM_OFS[7:2]);
    wire sel_d1 = (cfg_addr_i[7:2] == ipt_pkg::D1_TIM_OFS[7:2]);

    // RULE2: I/O space flag
    // RULE3: reserved bits read zero
    wire [31:0] bm_read = {16'h0000, bm_base_r, 3'h0, ipt_pkg::BM_IO_FLAG};
    // RULE15: both channels in one word
    wire [31:0] tim_read = {chan_tim_r[1], chan_tim_r[0]};
    wire [31:0] d1_read = {24'h00_0000, d1_tim_r};
    // Unmapped offsets read as zero
    wire [31:0] cfg_read = sel_bm ? bm_read :
                           sel_tim ? tim_read :
                           sel_d1 ? d1_read : 32'h0000_0000;

    // RULE1: base field writes
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            bm_base_r <= ipt_pkg::BM_BASE_RESET[15:4];
        end
        else if (cfg_wr && sel_bm)
        begin
            if (cfg_be_i[0])
            begin
                bm_base_r[7:4] <= cfg_wdata_i[7:4];
            end
            if (cfg_be_i[1])
            begin
                bm_base_r[15:8] <= cfg_wdata_i[15:8];
            end
        end
    end

    // RULE15: per-channel timing writes
    // RULE21: zero after reset
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            chan_tim_r[0] <= ipt_pkg::CHAN_TIM_RESET;
            chan_tim_r[1] <= ipt_pkg::CHAN_TIM_RESET;
            d1_tim_r <= ipt_pkg::D1_TIM_RESET;
        end
        else if (cfg_wr)
        begin
            if (sel_tim && cfg_be_i[0])
            begin
                chan_tim_r[0][7:0] <= cfg_wdata_i[7:0];
            end
            if (sel_tim && cfg_be_i[1])
            begin
                chan_tim_r[0][15:8] <= cfg_wdata_i[15:8];
            end
            if (sel_tim && cfg_be_i[2])
            begin
                chan_tim_r[1][7:0] <= cfg_wdata_i[23:16];
            end
            if (sel_tim && cfg_be_i[3])
            begin
                chan_tim_r[1][15:8] <= cfg_wdata_i[31:24];
            end
            if (sel_d1 && cfg_be_i[0])
            begin
                d1_tim_r <= cfg_wdata_i[7:0];
            end
        end
    end

    // Read data registered, answer one cycle later
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            cfg_rdata_r <= 32'h0000_0000;
            cfg_rvalid_r <= 1'b0;
        end
        else
        begin
            cfg_rvalid_r <= cfg_rd;
            if (cfg_rd)
            begin
                cfg_rdata_r <= cfg_read;
            end
        end
    end

    assign cfg_rdata_o = cfg_rdata_r;
    assign cfg_rvalid_o = cfg_rvalid_r;

    // RULE1: 16-byte window match
    assign bm_hit_o = io_req_i
                      && (io_addr_i[15:4] == bm_base_r);

    ipt_timing_if tif [2] ();

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chan
            wire [15:0] tim = chan_tim_r[g];
            wire [15:0] cmd_base = (g == 0) ? ipt_pkg::PRI_CMD_BASE
                                            : ipt_pkg::SEC_CMD_BASE;
            wire [15:0] ctl_addr = (g == 0) ? ipt_pkg::PRI_CTL_ADDR
                                            : ipt_pkg::SEC_CTL_ADDR;
            wire cmd_hit = (io_addr_i[15:3] == cmd_base[15:3]);
            wire ctl_hit = (io_addr_i == ctl_addr);
            wire data_port = cmd_hit
                             && (io_addr_i[2:0] == ipt_pkg::DATA_PORT_OFS);
            wire drv = drive_sel_r[g];

            // RULE4: positive decode when enabled
            assign hit[g] = io_req_i && tim[ipt_pkg::DECODE_EN_BIT]
                            && (cmd_hit || ctl_hit);
            assign acc[g] = hit[g] && !tif[g].busy;

            // Shadow of the drive-select bit, taken on accepted writes
            assign sel_wr[g] = acc[g] && io_wr_i && cmd_hit
                               && (io_addr_i[2:0] == ipt_pkg::DRIVE_SEL_OFS);
            always_ff @(posedge mclk_i)
            begin
                if (!rst_n_i)
                begin
                    drive_sel_r[g] <= 1'b0;
                end
                else if (sel_wr[g])
                begin
                    drive_sel_r[g] <= io_wdata_i[ipt_pkg::DRIVE_SEL_BIT];
                end
            end

            // RULE5: drive 1 uses its own register
            // RULE16: only with per-drive enable
            wire use_d1 = tim[ipt_pkg::PER_DRIVE_BIT] && drv;
            // RULE17: secondary sample 7:6
            // RULE19: primary sample 3:2
            wire [1:0] d1_sample = d1_tim_r[ipt_pkg::D1_CHAN_STRIDE * g
                                   + ipt_pkg::D1_SAMPLE_LSB +: 2];
            // RULE18: secondary recovery 5:4
            // RULE20: primary recovery 1:0
            wire [1:0] d1_recov = d1_tim_r[ipt_pkg::D1_CHAN_STRIDE * g
                                  + ipt_pkg::D1_RECOV_LSB +: 2];
            wire [1:0] sample_code = use_d1 ? d1_sample
                                     : tim[ipt_pkg::SAMPLE_LSB +: 2];
            wire [1:0] recov_code = use_d1 ? d1_recov
                                    : tim[ipt_pkg::RECOV_LSB +: 2];

            wire dma_only = drv ? tim[ipt_pkg::DMA_ONLY_D1_BIT]
                                : tim[ipt_pkg::DMA_ONLY_D0_BIT];
            wire fast_bank = drv ? tim[ipt_pkg::FAST_D1_BIT]
                                 : tim[ipt_pkg::FAST_D0_BIT];
            wire pp_en = drv ? tim[ipt_pkg::PREFETCH_D1_BIT]
                             : tim[ipt_pkg::PREFETCH_D0_BIT];
            wire rdy_en = drv ? tim[ipt_pkg::READY_D1_BIT]
                              : tim[ipt_pkg::READY_D0_BIT];

            // RULE8: DMA-only keeps PIO compatible
            // RULE13: fast for selected drive
            wire fast = data_port && fast_bank && (io_dma_i || !dma_only);
            // RULE12: data port compatible 16-bit
            // RULE14: other ports compatible 8-bit
            wire [1:0] eff_sample = fast ? sample_code :
                                    data_port ?
                                    ipt_pkg::COMPAT16_SAMPLE_CODE :
                                    ipt_pkg::COMPAT8_SAMPLE_CODE;
            wire [1:0] eff_recov = fast ? recov_code :
                                   data_port ?
                                   ipt_pkg::COMPAT16_RECOV_CODE :
                                   ipt_pkg::COMPAT8_RECOV_CODE;

            assign tif[g].start = acc[g];
            // RULE6: sample-point count
            assign tif[g].sample_clks = ipt_pkg::ipt_sample_clks(eff_sample);
            // RULE7: recovery count
            assign tif[g].recov_clks = ipt_pkg::ipt_recov_clks(eff_recov);
            // RULE10: ready sampling enable per drive
            assign tif[g].ready_en = rdy_en;
            assign tif[g].fast = fast;
            // RULE9: prefetch/post on data port
            assign tif[g].prefetch = data_port && pp_en;
            assign tif[g].wr = io_wr_i;

            ipt_cycle_timer u_timer (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .tif(tif[g]),
                .iordy_i(iordy_i[g]),
                .strobe_o(strobe_o[g]),
                .fast_o(fast_o[g]),
                .prefetch_o(prefetch_o[g]),
                .wr_o(wr_o[g])
            );

            assign busy_o[g] = tif[g].busy;
            assign done_o[g] = tif[g].done;
        end
    endgenerate

    // Unclaimed cycles fall through to ISA outside this block
    assign io_claim_o = |hit;
    assign io_ack_o = |acc;
    assign drive_sel_o = drive_sel_r;
endmodule // ipt_ide_timing
